// *** hw/otc_pkg.sv ***
package otc_pkg;

   // register word offsets on the host port
   localparam logic [7:0]  ADDR_HF_ADJ   = 8'h09;
   localparam logic [7:0]  ADDR_HF_CAL   = 8'h0A;
   localparam logic [7:0]  ADDR_LF_ADJ   = 8'h0B;
   localparam logic [7:0]  ADDR_SLOW_ARM = 8'h0C;
   localparam logic [7:0]  ADDR_STAMP_L  = 8'h11;
   localparam logic [7:0]  ADDR_STAMP_H  = 8'h12;
   localparam logic [7:0]  ADDR_DELTA    = 8'h13;

   // field widths and bit positions
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 16;
   localparam int          HF_CODE_W     = 8;
   localparam int          LF_CODE_W     = 10;
   localparam int          TRIM_W        = 6;
   localparam int          TALLY_W       = 15;
   localparam int          CAL_GO_BIT    = 15;
   localparam int          ARM_BIT       = 15;

   // reset values
   localparam logic [7:0]  RST_HF_CODE   = 8'h90;
   localparam logic [9:0]  RST_LF_CODE   = 10'h2B2;
   localparam logic [5:0]  RST_SLOW_TRIM = 6'h12;

   // calibration windows in low frequency cycles
   localparam logic [7:0]  WIN_FAST      = 8'h80;
   localparam logic [7:0]  WIN_SLOW      = 8'h20;

   // one host register access
   typedef struct packed {
      logic [7:0]  addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } otc_req_t;

   // one coherent timestamp snapshot
   typedef struct packed {
      logic [31:0] count;
      logic [15:0] slot;
   } otc_stamp_t;

endpackage : otc_pkg

// *** hw/otc_cal_counter.sv ***
`timescale 1ns/1ps
module otc_cal_counter #(
   parameter logic [7:0] WIN_FAST = otc_pkg::WIN_FAST,
   parameter logic [7:0] WIN_SLOW = otc_pkg::WIN_SLOW
) (
   input  wire logic                         clock,
   input  wire logic                         rst_n,
   input  wire logic                         start,
   input  wire logic                         lf_is_slow,
   input  wire logic                         hf_tick,
   input  wire logic                         lf_tick,
   output logic                              done,
   output logic [otc_pkg::TALLY_W-1:0]       tally
);

   typedef enum logic [2:0] {
      CAL_IDLE  = 3'b001,
      CAL_ALIGN = 3'b010,
      CAL_COUNT = 3'b100
   } otc_cal_state_t;

   otc_cal_state_t               state;
   logic [7:0]                   win;
   logic [7:0]                   lf_cnt;
   logic [otc_pkg::TALLY_W-1:0]  hf_cnt;
   logic                         last_lf;

   // saturating increment, so a runaway oscillator pins the tally high
   function automatic logic [otc_pkg::TALLY_W-1:0] sat_inc(
      input logic [otc_pkg::TALLY_W-1:0] v);
      sat_inc = (&v) ? v : v + 15'h0001;
   endfunction : sat_inc

   assign last_lf = (state == CAL_COUNT) && lf_tick && (lf_cnt == win - 8'h01);
   assign done    = last_lf;

   // sequencer: align to an lf edge, then count a fixed lf window
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= CAL_IDLE;
         win   <= 8'h00;
      end else begin
         case (state)
            CAL_IDLE: begin
               if (start) begin
                  state <= CAL_ALIGN;
                  win   <= lf_is_slow ? WIN_SLOW : WIN_FAST;
               end
            end
            CAL_ALIGN: begin
               if (lf_tick) begin
                  state <= CAL_COUNT;
               end
            end
            CAL_COUNT: begin
               if (last_lf) begin
                  state <= CAL_IDLE;
               end
            end
            default: state <= CAL_IDLE;
         endcase
      end
   end

   // window and hf counters
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lf_cnt <= 8'h00;
         hf_cnt <= 15'h0000;
      end else if (state != CAL_COUNT) begin
         lf_cnt <= 8'h00;
         hf_cnt <= 15'h0000;
      end else begin
         if (lf_tick) begin
            lf_cnt <= lf_cnt + 8'h01;
         end
         if (hf_tick) begin
            hf_cnt <= sat_inc(hf_cnt);
         end
      end
   end

   // result holds until the next window closes
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tally <= 15'h0000;
      end else if (last_lf) begin
         tally <= hf_tick ? sat_inc(hf_cnt) : hf_cnt;
      end
   end

   property p_win_fast;
      @(posedge clock) disable iff (!rst_n)
      (done && win == WIN_FAST) |-> (lf_cnt == 8'h7F);
   endproperty
   a_win_fast: assert property (p_win_fast) else $error("fast window length wrong");

   property p_win_slow;
      @(posedge clock) disable iff (!rst_n)
      (done && win == WIN_SLOW) |-> (lf_cnt == 8'h1F);
   endproperty
   a_win_slow: assert property (p_win_slow) else $error("slow window length wrong");

   property p_tally_hold;
      @(posedge clock) disable iff (!rst_n)
      !done |=> $stable(tally);
   endproperty
   a_tally_hold: assert property (p_tally_hold) else $error("tally changed off window");

endmodule : otc_cal_counter

// *** hw/otc_stamp.sv ***
`timescale 1ns/1ps
module otc_stamp (
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic                arm,
   input  wire logic                stamp_in,
   input  wire otc_pkg::otc_stamp_t sample,
   output logic                     capture,
   output otc_pkg::otc_stamp_t      snap
);

   logic stamp_prev;

   // previous level resets high so a pin already high is not a rise
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stamp_prev <= 1'b1;
      end else begin
         stamp_prev <= stamp_in;
      end
   end

   assign capture = arm && stamp_in && !stamp_prev;

   // count and slot delta taken in the same edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         snap <= '0;
      end else if (capture) begin
         snap <= sample;
      end
   end

   property p_snap_coherent;
      @(posedge clock) disable iff (!rst_n)
      capture |=> (snap == $past(sample));
   endproperty
   a_snap_coherent: assert property (p_snap_coherent) else $error("snapshot mixed");

endmodule : otc_stamp

// *** hw/otc_top.sv ***
`timescale 1ns/1ps
// Behaviour
// - eight-bit hf trim code, 0x00 slowest to 0xFF fastest, resets to 0x90.
// - writing one to cal bit 15 starts an hf calibration.
// - with the 1 MHz lf setting, count hf cycles over 128 lf cycles.
// - with the 32 kHz lf setting, count hf cycles over 32 lf cycles.
// - total hf count loads into 15-bit tally and holds until next run.
// - calibration hardware clears the start bit when the run completes.
// - ten-bit lf trim code, 0x000 slowest to 0x3FF fastest, resets to 0x2B2.
// - while armed, the next rising edge of the stamp input captures.
// - capture clears the arm bit unless a host write lands in the same cycle, so one edge per arming.
// - six-bit slow trim, 0 fastest, 0x12 default, 0x3F slowest.
// - capture latches the 32-bit counter as low and high 16-bit halves.
// - capture also records the count remaining to the next slot start.
module otc_top (
   input  wire logic                          clock,
   input  wire logic                          rst_b,
   input  wire otc_pkg::otc_req_t             reg_req,
   output logic [otc_pkg::DATA_W-1:0]         rd_data,
   output logic                               rd_valid,
   input  wire logic                          lf_is_slow,
   input  wire logic                          hf_tick,
   input  wire logic                          lf_tick,
   input  wire logic                          general_pin_zero,
   input  wire logic                          alt_stamp_pin,
   input  wire logic                          stamp_pin_sel,
   input  wire logic [31:0]                   stamp_counter,
   input  wire logic [15:0]                   slot_remaining_in,
   output logic [otc_pkg::HF_CODE_W-1:0]      hf_freq_code,
   output logic [otc_pkg::LF_CODE_W-1:0]      lf_freq_code,
   output logic [otc_pkg::TRIM_W-1:0]         slow_osc_trim,
   output logic                               hf_cal_busy
);

   logic                          rst_meta;
   logic                          rst_n;
   logic                          hf_cal_go;
   logic                          capture_arm;
   logic                          cal_start;
   logic                          cal_done;
   logic                          stamp_capture;
   logic                          stamp_in;
   logic [otc_pkg::TALLY_W-1:0]   hf_cal_tally;
   otc_pkg::otc_stamp_t           stamp_sample;
   otc_pkg::otc_stamp_t           stamp_snap;
   logic [otc_pkg::DATA_W-1:0]    next_rd_data;

   // reset enters asynchronously, released through two flops
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // write decode helper
   function automatic logic wr_hit(
      input otc_pkg::otc_req_t r,
      input logic [7:0]        a);
      wr_hit = r.wr && (r.addr == a);
   endfunction : wr_hit

   // a second start while busy is dropped, not queued
   assign cal_start = wr_hit(reg_req, otc_pkg::ADDR_HF_CAL)
                      && reg_req.wdata[otc_pkg::CAL_GO_BIT]
                      && !hf_cal_go;
   assign hf_cal_busy = hf_cal_go;

   // hf trim code, straight to the oscillator core
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hf_freq_code <= otc_pkg::RST_HF_CODE;
      end else if (wr_hit(reg_req, otc_pkg::ADDR_HF_ADJ)) begin
         hf_freq_code <= reg_req.wdata[otc_pkg::HF_CODE_W-1:0];
      end
   end

   // lf trim code, straight to the oscillator core
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lf_freq_code <= otc_pkg::RST_LF_CODE;
      end else if (wr_hit(reg_req, otc_pkg::ADDR_LF_ADJ)) begin
         lf_freq_code <= reg_req.wdata[otc_pkg::LF_CODE_W-1:0];
      end
   end

   // slow trim: inverted sense, larger code runs slower
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         slow_osc_trim <= otc_pkg::RST_SLOW_TRIM;
      end else if (wr_hit(reg_req, otc_pkg::ADDR_SLOW_ARM)) begin
         slow_osc_trim <= reg_req.wdata[otc_pkg::TRIM_W-1:0];
      end
   end

   // start bit doubles as the busy flag software polls
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hf_cal_go <= 1'b0;
      end else if (cal_done) begin
         hf_cal_go <= 1'b0;
      end else if (cal_start) begin
         hf_cal_go <= 1'b1;
      end
   end

   // arm bit: a host write in the capture cycle wins and loads bit 15
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         capture_arm <= 1'b0;
      end else if (wr_hit(reg_req, otc_pkg::ADDR_SLOW_ARM)) begin
         capture_arm <= reg_req.wdata[otc_pkg::ARM_BIT];
      end else if (stamp_capture) begin
         capture_arm <= 1'b0;
      end
   end

   otc_cal_counter u_cal (
      .clock      (clock),
      .rst_n      (rst_n),
      .start      (cal_start),
      .lf_is_slow (lf_is_slow),
      .hf_tick    (hf_tick),
      .lf_tick    (lf_tick),
      .done       (cal_done),
      .tally      (hf_cal_tally)
   );

   // stamp source select, general pin zero by default
   assign stamp_in           = stamp_pin_sel ? alt_stamp_pin : general_pin_zero;
   assign stamp_sample.count = stamp_counter;
   assign stamp_sample.slot  = slot_remaining_in;

   otc_stamp u_stamp (
      .clock    (clock),
      .rst_n    (rst_n),
      .arm      (capture_arm),
      .stamp_in (stamp_in),
      .sample   (stamp_sample),
      .capture  (stamp_capture),
      .snap     (stamp_snap)
   );

   // read mux; unmapped addresses read as zero
   always_comb begin
      next_rd_data = 16'h0000;
      case (reg_req.addr)
         otc_pkg::ADDR_HF_ADJ:   next_rd_data = {8'h00, hf_freq_code};
         otc_pkg::ADDR_HF_CAL:   next_rd_data = {hf_cal_go, hf_cal_tally};
         otc_pkg::ADDR_LF_ADJ:   next_rd_data = {6'h00, lf_freq_code};
         otc_pkg::ADDR_SLOW_ARM: next_rd_data = {capture_arm, 9'h000, slow_osc_trim};
         otc_pkg::ADDR_STAMP_L:  next_rd_data = stamp_snap.count[15:0];
         otc_pkg::ADDR_STAMP_H:  next_rd_data = stamp_snap.count[31:16];
         otc_pkg::ADDR_DELTA:    next_rd_data = stamp_snap.slot;
         default:                next_rd_data = 16'h0000;
      endcase
   end

   // read answer one cycle after the strobe, held until next read
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_data  <= 16'h0000;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= reg_req.rd;
         if (reg_req.rd) begin
            rd_data <= next_rd_data;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_hf_code;
      wr_hit(reg_req, otc_pkg::ADDR_HF_ADJ) |=> hf_freq_code == $past(reg_req.wdata[7:0]);
   endproperty
   a_hf_code: assert property (p_hf_code) else $error("hf code not written");

   property p_cal_start;
      cal_start |=> hf_cal_go ##1 (hf_cal_go || $past(cal_done));
   endproperty
   a_cal_start: assert property (p_cal_start) else $error("calibration did not start");

   property p_go_clear;
      cal_done |=> !hf_cal_go;
   endproperty
   a_go_clear: assert property (p_go_clear) else $error("start bit not cleared");

   property p_lf_code;
      wr_hit(reg_req, otc_pkg::ADDR_LF_ADJ) |=> lf_freq_code == $past(reg_req.wdata[9:0]);
   endproperty
   a_lf_code: assert property (p_lf_code) else $error("lf code not written");

   property p_trim;
      wr_hit(reg_req, otc_pkg::ADDR_SLOW_ARM) |=> slow_osc_trim == $past(reg_req.wdata[5:0]);
   endproperty
   a_trim: assert property (p_trim) else $error("slow trim not written");

   property p_capture_edge;
      (capture_arm && stamp_in && !$past(stamp_in)) |-> stamp_capture;
   endproperty
   a_capture_edge: assert property (p_capture_edge) else $error("armed edge missed");

   property p_arm_clear;
      (stamp_capture && !wr_hit(reg_req, otc_pkg::ADDR_SLOW_ARM)) |=> !capture_arm;
   endproperty
   a_arm_clear: assert property (p_arm_clear) else $error("arm not cleared");

   // a capture in the read cycle lands after the mux has sampled the old snapshot
   property p_stamp_read_hi;
      (reg_req.rd && reg_req.addr == otc_pkg::ADDR_STAMP_H)
         |=> rd_data == $past(stamp_snap.count[31:16]);
   endproperty
   a_stamp_read_hi: assert property (p_stamp_read_hi) else $error("high half wrong");

   property p_delta_read;
      (reg_req.rd && reg_req.addr == otc_pkg::ADDR_DELTA)
         |=> rd_data == $past(stamp_snap.slot);
   endproperty
   a_delta_read: assert property (p_delta_read) else $error("slot delta read wrong");

   property p_busy_write;
      (hf_cal_go && wr_hit(reg_req, otc_pkg::ADDR_HF_CAL) && !cal_done) |=> hf_cal_go;
   endproperty
   a_busy_write: assert property (p_busy_write) else $error("restart during run");

   // software polling right behind the closing tick must already see idle
   property p_tally_read;
      cal_done ##1 !cal_start ##1 (reg_req.rd && reg_req.addr == otc_pkg::ADDR_HF_CAL)
         |=> rd_data[15] == 1'b0;
   endproperty
   a_tally_read: assert property (p_tally_read) else $error("done not visible");

   property p_rd_pulse;
      rd_valid == $past(reg_req.rd);
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read answer late");

   property p_rd_hold;
      !reg_req.rd |=> $stable(rd_data);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

   // read of a register written in the same cycle returns the old value
   property p_hf_read;
      (reg_req.rd && reg_req.addr == otc_pkg::ADDR_HF_ADJ)
         |=> rd_data == {8'h00, $past(hf_freq_code)};
   endproperty
   a_hf_read: assert property (p_hf_read) else $error("hf code read wrong");

   property p_lf_read;
      (reg_req.rd && reg_req.addr == otc_pkg::ADDR_LF_ADJ)
         |=> rd_data == {6'h00, $past(lf_freq_code)};
   endproperty
   a_lf_read: assert property (p_lf_read) else $error("lf code read wrong");

   property p_slow_read;
      (reg_req.rd && reg_req.addr == otc_pkg::ADDR_SLOW_ARM)
         |=> rd_data == {$past(capture_arm), 9'h000, $past(slow_osc_trim)};
   endproperty
   a_slow_read: assert property (p_slow_read) else $error("arm and trim read wrong");

   property p_stamp_read_lo;
      (reg_req.rd && reg_req.addr == otc_pkg::ADDR_STAMP_L)
         |=> rd_data == $past(stamp_snap.count[15:0]);
   endproperty
   a_stamp_read_lo: assert property (p_stamp_read_lo) else $error("low half wrong");

   property p_hf_hold;
      !wr_hit(reg_req, otc_pkg::ADDR_HF_ADJ) |=> $stable(hf_freq_code);
   endproperty
   a_hf_hold: assert property (p_hf_hold) else $error("hf code moved");

   property p_lf_hold;
      !wr_hit(reg_req, otc_pkg::ADDR_LF_ADJ) |=> $stable(lf_freq_code);
   endproperty
   a_lf_hold: assert property (p_lf_hold) else $error("lf code moved");

   property p_trim_hold;
      !wr_hit(reg_req, otc_pkg::ADDR_SLOW_ARM) |=> $stable(slow_osc_trim);
   endproperty
   a_trim_hold: assert property (p_trim_hold) else $error("slow trim moved");

   property p_go_hold;
      (!cal_start && !cal_done) |=> $stable(hf_cal_go);
   endproperty
   a_go_hold: assert property (p_go_hold) else $error("busy flag moved");

   property p_done_busy;
      cal_done |-> hf_cal_go;
   endproperty
   a_done_busy: assert property (p_done_busy) else $error("done while idle");

   property p_capture_armed;
      stamp_capture |-> capture_arm;
   endproperty
   a_capture_armed: assert property (p_capture_armed) else $error("capture unarmed");

   property p_arm_hold;
      (!stamp_capture && !wr_hit(reg_req, otc_pkg::ADDR_SLOW_ARM)) |=> $stable(capture_arm);
   endproperty
   a_arm_hold: assert property (p_arm_hold) else $error("arm bit moved");

   property p_rearm;
      wr_hit(reg_req, otc_pkg::ADDR_SLOW_ARM)
         |=> capture_arm == $past(reg_req.wdata[otc_pkg::ARM_BIT]);
   endproperty
   a_rearm: assert property (p_rearm) else $error("arm write lost");

   property p_snap_hold;
      !stamp_capture |=> $stable(stamp_snap);
   endproperty
   a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved");

   c_cal_fast: cover property (cal_done && !lf_is_slow);
   c_cal_slow: cover property (cal_done && lf_is_slow);
   c_capture:  cover property (stamp_capture);
   c_rearm:    cover property (stamp_capture && wr_hit(reg_req, otc_pkg::ADDR_SLOW_ARM));

endmodule : otc_top

// *** dv/test_osc_trim_cal_timestamp.sv ***
`timescale 1ns/1ps
module test_osc_trim_cal_timestamp;

   // one compare, counted; macro args must be free of side effects
   `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); end end

   logic              clock;
   logic              rst_b;
   otc_pkg::otc_req_t req;
   logic [15:0]       rd_data;
   logic              rd_valid;
   logic              lf_is_slow, hf_tick, lf_tick, stamp_pin_sel;
   logic              general_pin_zero, alt_stamp_pin;
   logic [31:0]       stamp_counter, e_cnt, cap_cnt;
   logic [15:0]       slot_remaining_in, e_slot, cap_slot, seed, wv, exp_v;
   logic [7:0]        hf_freq_code;
   logic [9:0]        lf_freq_code;
   logic [5:0]        slow_osc_trim;
   logic              hf_cal_busy;
   logic [1:0]        lf_ph;
   logic [15:0]       exp_q [$];
   int                err_count, compares, cyc;
   logic [7:0]        map_addr [8] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h11, 8'h12, 8'h13, 8'h20};
   logic [15:0]       map_rst [8]  = '{16'h0090, 16'h0000, 16'h02B2, 16'h0012,
                                       16'h0000, 16'h0000, 16'h0000, 16'h0000};

   otc_top otc_top_inst (
      .clock             (clock),
      .rst_b             (rst_b),
      .reg_req           (req),
      .rd_data           (rd_data),
      .rd_valid          (rd_valid),
      .lf_is_slow        (lf_is_slow),
      .hf_tick           (hf_tick),
      .lf_tick           (lf_tick),
      .general_pin_zero  (general_pin_zero),
      .alt_stamp_pin     (alt_stamp_pin),
      .stamp_pin_sel     (stamp_pin_sel),
      .stamp_counter     (stamp_counter),
      .slot_remaining_in (slot_remaining_in),
      .hf_freq_code      (hf_freq_code),
      .lf_freq_code      (lf_freq_code),
      .slow_osc_trim     (slow_osc_trim),
      .hf_cal_busy       (hf_cal_busy)
   );

   // 40 ns clock
   always #20 clock = ~clock;

   // cycle count of rising edges, for the calibration span
   always @(posedge clock) cyc <= cyc + 1;

   // hf at half the clock, lf every fourth cycle: any window of n lf cycles holds 2n hf ticks
   always @(negedge clock) begin
      hf_tick <= ~hf_tick;
      lf_ph   <= lf_ph + 2'd1;
      lf_tick <= (lf_ph == 2'd3);
   end

   // read answers are settled by the falling edge; oldest note first
   always @(negedge clock) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            err_count++;
            $display("mismatch read data expected none seen %h", rd_data);
         end else begin
            exp_v = exp_q.pop_front();
            `CHK("read data", exp_v, rd_data)
         end
      end
   end

   // run watchdog: a hang anywhere in the test counts against the run
   initial begin
      #(40 * 20000);
      err_count++;
      give_verdict();
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic give_verdict();
      if (err_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   // one access, held a full cycle; a read notes its expected data
   task automatic access(input logic [7:0] a, input logic w, input logic [15:0] d);
      @(negedge clock);
      req = '{addr: a, wr: w, rd: ~w, wdata: d};
      if (!w) exp_q.push_back(d);
      @(negedge clock);
      req = '0;
   endtask : access

   // rising edge on one stamp input; counter moves right after, so a late sample shows
   task automatic stamp_edge(input logic use_alt);
      @(negedge clock);
      general_pin_zero = 1'b0;
      alt_stamp_pin    = 1'b0;
      @(negedge clock);
      seed              = lfsr(seed);
      e_cnt             = {seed, ~seed};
      e_slot            = seed ^ 16'h5A5A;
      stamp_counter     = e_cnt;
      slot_remaining_in = e_slot;
      if (use_alt) alt_stamp_pin = 1'b1;
      else general_pin_zero = 1'b1;
      @(negedge clock);
      seed              = lfsr(seed);
      stamp_counter     = {~seed, seed};
      slot_remaining_in = seed;
   endtask : stamp_edge

   task automatic check_snap();
      access(8'h11, 1'b0, cap_cnt[15:0]);
      access(8'h12, 1'b0, cap_cnt[31:16]);
      access(8'h13, 1'b0, cap_slot);
   endtask : check_snap

   // one calibration with a zero write and a restart attempt in mid-run
   task automatic run_cal(input logic slow, input logic [15:0] prev, input int win);
      int c0;
      int d;
      lf_is_slow = slow;
      access(8'h0A, 1'b1, 16'h8000);
      c0 = cyc;
      `CHK("cal busy", 1'b1, hf_cal_busy)
      access(8'h0A, 1'b0, 16'h8000 | prev);
      access(8'h0A, 1'b1, 16'h0000);
      `CHK("cal busy", 1'b1, hf_cal_busy)
      repeat (20) @(negedge clock);
      access(8'h0A, 1'b1, 16'h8000);
      d = 0;
      while (hf_cal_busy !== 1'b0 && d < 2000) begin
         @(negedge clock);
         d++;
      end
      d = cyc - c0;
      `CHK("cal span", 1'b1, (d >= win * 4 && d <= win * 4 + 6))
      access(8'h0A, 1'b0, 16'(win * 2));
   endtask : run_cal

   initial begin
      clock = 1'b0; rst_b = 1'b0; req = '0; lf_is_slow = 1'b0;
      hf_tick = 1'b0; lf_tick = 1'b0; lf_ph = 2'd0; stamp_pin_sel = 1'b0;
      general_pin_zero = 1'b0; alt_stamp_pin = 1'b0; stamp_counter = '0;
      slot_remaining_in = '0; seed = 16'h0055; cap_cnt = '0; cap_slot = '0;
      err_count = 0; compares = 0; cyc = 0;
      repeat (16) @(negedge clock);
      rst_b = 1'b1;
      repeat (4) @(negedge clock);

      // reset values, unmapped address last
      `CHK("hf code", 8'h90, hf_freq_code)
      `CHK("lf code", 10'h2B2, lf_freq_code)
      `CHK("slow trim", 6'h12, slow_osc_trim)
      for (int i = 0; i < 8; i++) access(map_addr[i], 1'b0, map_rst[i]);

      // trim codes at both ends, then random; read-only stamp ignores writes
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         wv = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed;
         access(8'h09, 1'b1, wv);
         access(8'h0B, 1'b1, wv);
         access(8'h0C, 1'b1, wv & 16'h7FFF);
         access(8'h11, 1'b1, wv);
         access(8'h09, 1'b0, wv & 16'h00FF);
         access(8'h0B, 1'b0, wv & 16'h03FF);
         access(8'h0C, 1'b0, wv & 16'h003F);
         access(8'h11, 1'b0, 16'h0000);
         `CHK("hf code", wv[7:0], hf_freq_code)
         `CHK("lf code", wv[9:0], lf_freq_code)
         `CHK("slow trim", wv[5:0], slow_osc_trim)
      end

      // fast then slow window; tally holds and ignores writes
      run_cal(1'b0, 16'h0000, int'(otc_pkg::WIN_FAST));
      run_cal(1'b1, 16'(2 * int'(otc_pkg::WIN_FAST)), int'(otc_pkg::WIN_SLOW));
      access(8'h0A, 1'b1, 16'h7FFF);
      access(8'h0A, 1'b0, 16'(2 * int'(otc_pkg::WIN_SLOW)));

      // unarmed edge, armed edge, second edge, wrong pin, alternate pin, disarm
      stamp_edge(1'b0);
      check_snap();
      access(8'h0C, 1'b1, 16'h8015);
      access(8'h0C, 1'b0, 16'h8015);
      stamp_edge(1'b0);
      cap_cnt = e_cnt;
      cap_slot = e_slot;
      access(8'h0C, 1'b0, 16'h0015);
      check_snap();
      stamp_edge(1'b0);
      check_snap();
      stamp_pin_sel = 1'b1;
      access(8'h0C, 1'b1, 16'h8015);
      stamp_edge(1'b0);
      access(8'h0C, 1'b0, 16'h8015);
      stamp_edge(1'b1);
      cap_cnt = e_cnt;
      cap_slot = e_slot;
      access(8'h0C, 1'b0, 16'h0015);
      check_snap();
      access(8'h0C, 1'b1, 16'h8015);
      access(8'h0C, 1'b1, 16'h0015);
      stamp_edge(1'b1);
      check_snap();

      repeat (4) @(negedge clock);
      // a read that never answered leaves its note behind
      `CHK("reads left", 0, exp_q.size())
      give_verdict();
   end

endmodule : test_osc_trim_cal_timestamp
